// ===== verilog/nv_access_defines.vh
`ifndef NV_ACCESS_DEFINES_VH
`define NV_ACCESS_DEFINES_VH

// ----------------------------------------
// Register offsets (I/O space, data space adds the I/O offset)
// ----------------------------------------
`define NV_IO_TO_DATA_OFFSET 8'h20
`define NV_CTRL_ADDR 6'h1f
`define NV_DATA_ADDR 6'h20
`define NV_ADDR_LOW_ADDR 6'h21
`define NV_ADDR_HIGH_ADDR 6'h22

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define NV_CTRL_READ_STROBE 0
`define NV_CTRL_PROG_STROBE 1
`define NV_CTRL_MASTER_EN 2
`define NV_CTRL_READY_IE 3
`define NV_CTRL_MODE_LSB 4
`define NV_CTRL_MODE_MSB 5
`define NV_MODE_RESET 2'h0
`define NV_MODE_ATOMIC 2'h0
`define NV_MODE_ERASE 2'h1
`define NV_MODE_WRITE 2'h2
`define NV_MODE_RSVD 2'h3

// ----------------------------------------
// Widths and timing
// ----------------------------------------
`define NV_ADDR_W 12
`define NV_DEPTH 4096
`define NV_ERASED_BYTE 8'hff
`define NV_READ_STALL 3'h4
`define NV_WRITE_STALL 3'h2
`define NV_MASTER_WINDOW 3'h4
`define NV_OSC_ATOMIC_CYCLES 26368
`define NV_OSC_SPLIT_CYCLES 13184

`endif

// ===== verilog/nv_byte_store.v
`timescale 1ns/1ps
`include "nv_access_defines.vh"

module nv_byte_store (
  // Clock
  input wire ref_clk_i,
  // Access port
  input wire [11:0] addr_i,
  input wire wr_en_i,
  input wire [7:0] wr_data_i,
  output reg [7:0] rd_data_o
);

  reg [7:0] mem [0:`NV_DEPTH-1];

  // Byte array with registered read data, no reset so contents survive
  always @(posedge ref_clk_i) begin
    if (wr_en_i) begin
      mem[addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[addr_i];
  end

endmodule

// ===== verilog/nv_osc_timer.v
`timescale 1ns/1ps
`include "nv_access_defines.vh"

module nv_osc_timer (
  // Clock and reset
  input wire ref_clk_i,
  input wire nrst_i,
  // Oscillator tick enable, one cycle wide
  input wire osc_tick_i,
  // Control
  input wire start_i,
  input wire [14:0] load_i,
  output reg done_o
);

  reg [14:0] count_reg;
  reg run_reg;

  // Counts oscillator ticks down; done pulses when the count runs out
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count_reg <= 15'h0000;
      run_reg <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        count_reg <= load_i;
        run_reg <= 1'b1;
      end else if (run_reg && osc_tick_i) begin
        if (count_reg <= 15'h0001) begin
          run_reg <= 1'b0;
          done_o <= 1'b1;
        end
        count_reg <= count_reg - 15'h0001;
      end
    end
  end

endmodule

// ===== verilog/nv_access_ctrl.v
`timescale 1ns/1ps
`include "nv_access_defines.vh"

// Function
// - Store is a separate linear space of individually read/written bytes.
// - Registers sit in I/O space; data-space addresses carry 0x20 offset.
// - Self-timed completion lets software see when next byte may be written.
// - Read trigger stalls the CPU four cycles.
// - Write start stalls the CPU two cycles.
// - Reset during programming lets the operation finish (core reset only; power-on reset aborts it).
// - Address is 16 bits; bits 11:0 used, 15:12 read zero.
// - Address is undefined after reset; software loads it before access.
// - Data register supplies write byte and receives read byte.
// - Mode 5:4: 00 atomic, 01 erase, 10 write, 11 reserved.
// - Mode writes ignored while program strobe is set.
// - Reset returns mode to 00 unless programming busy (power-on reset returns it to 00 even when busy).
// - Ready interrupt enabled by bit 3 and global interrupt enable.
// - Ready interrupt is a level while strobe clear and enabled.
// - Program strobe starts only within four cycles of master enable.
// - Hardware clears master enable four cycles after it is set.
// - Program strobe clears by hardware when programming time elapses.
// - Read strobe fetches the byte into data register at once.
// - While programming, reads refused and address changes blocked.
// - Programming timed by RC oscillator, 26368 cycles atomic.
module nv_access_ctrl (
  // Clock and resets; core reset does not stop a running operation
  input wire ref_clk_i,
  input wire nrst_i,
  input wire core_rst_i,
  // Calibrated RC oscillator, asynchronous to ref_clk_i
  input wire rc_osc_i,
  // I/O register bus from the CPU core
  input wire data_space_i,
  input wire [7:0] io_addr_i,
  input wire io_wr_i,
  input wire io_rd_i,
  input wire [7:0] io_wdata_i,
  output reg [7:0] io_rdata_o,
  output reg io_hit_o,
  // Core interface
  input wire global_int_en_i,
  output reg cpu_stall_o,
  output reg ready_irq_o,
  output reg busy_o
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_ERASE = 2'h1;
  localparam ST_PROG = 2'h2;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [11:0] addr_reg;
  reg [7:0] data_reg;
  reg [1:0] mode_reg;
  reg ready_ie_reg;
  reg master_reg;
  reg [2:0] master_cnt_reg;
  reg prog_reg;
  reg read_pend_reg;
  reg [2:0] stall_cnt_reg;
  reg [1:0] osc_sync_reg;
  reg osc_last_reg;
  reg [7:0] bus_addr;
  reg hit_ctrl;
  reg hit_data;
  reg hit_lo;
  reg hit_hi;
  reg [7:0] rdata_next;
  reg mem_wr;
  reg [7:0] mem_wdata;
  reg timer_start;
  reg [14:0] timer_load;
  wire timer_done;
  wire [7:0] mem_rdata;
  wire osc_tick;
  wire ctrl_wr;
  wire start_prog;

  // ----------------------------------------
  // Sub-blocks
  // ----------------------------------------
  nv_byte_store u_store (
    .ref_clk_i(ref_clk_i),
    .addr_i(addr_reg),
    .wr_en_i(mem_wr),
    .wr_data_i(mem_wdata),
    .rd_data_o(mem_rdata)
  );

  nv_osc_timer u_timer (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .osc_tick_i(osc_tick),
    .start_i(timer_start),
    .load_i(timer_load),
    .done_o(timer_done)
  );

  // ----------------------------------------
  // RC oscillator edge to tick enable
  // ----------------------------------------
  // Two-stage sync, edge taken from the second stage only
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      osc_sync_reg <= 2'h0;
      osc_last_reg <= 1'b0;
    end else begin
      osc_sync_reg <= {osc_sync_reg[0], rc_osc_i};
      osc_last_reg <= osc_sync_reg[1];
    end
  end

  assign osc_tick = osc_sync_reg[1] & ~osc_last_reg;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Data-space accesses are shifted back to I/O addresses
  always @* begin
    bus_addr = data_space_i ? (io_addr_i - `NV_IO_TO_DATA_OFFSET) : io_addr_i;
    hit_ctrl = (bus_addr == {2'h0, `NV_CTRL_ADDR});
    hit_data = (bus_addr == {2'h0, `NV_DATA_ADDR});
    hit_lo = (bus_addr == {2'h0, `NV_ADDR_LOW_ADDR});
    hit_hi = (bus_addr == {2'h0, `NV_ADDR_HIGH_ADDR});
  end

  assign ctrl_wr = io_wr_i & hit_ctrl & ~core_rst_i;
  assign start_prog = ctrl_wr & io_wdata_i[`NV_CTRL_PROG_STROBE] & master_reg & ~prog_reg;

  // ----------------------------------------
  // Programming sequencer
  // ----------------------------------------
  // Atomic runs erase then write; split modes run one phase
  always @* begin
    state_next = state_reg;
    mem_wr = 1'b0;
    mem_wdata = data_reg;
    timer_start = 1'b0;
    timer_load = 15'h0000;
    case (state_reg)
      ST_IDLE: begin
        if (start_prog && mode_reg != `NV_MODE_RSVD) begin
          timer_start = 1'b1;
          timer_load = 15'd`NV_OSC_SPLIT_CYCLES;
          state_next = (mode_reg == `NV_MODE_WRITE) ? ST_PROG : ST_ERASE;
        end
      end
      ST_ERASE: begin
        if (timer_done) begin
          mem_wr = 1'b1;
          mem_wdata = `NV_ERASED_BYTE;
          if (mode_reg == `NV_MODE_ATOMIC) begin
            timer_start = 1'b1;
            timer_load = 15'd`NV_OSC_SPLIT_CYCLES;
            state_next = ST_PROG;
          end else begin
            state_next = ST_IDLE;
          end
        end
      end
      ST_PROG: begin
        if (timer_done) begin
          mem_wr = 1'b1;
          // Write-only programs zeros into the erased cells
          mem_wdata = (mode_reg == `NV_MODE_WRITE) ? (mem_rdata & data_reg) : data_reg;
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Sequencer state, only the power-on reset clears it
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  // Address and data registers keep their content through core reset
  always @(posedge ref_clk_i) begin
    if (io_wr_i && !prog_reg && !core_rst_i) begin
      if (hit_lo) begin
        addr_reg[7:0] <= io_wdata_i;
      end
      if (hit_hi) begin
        addr_reg[11:8] <= io_wdata_i[3:0];
      end
    end
    if (read_pend_reg) begin
      data_reg <= mem_rdata;
    end else if (io_wr_i && hit_data && !core_rst_i) begin
      data_reg <= io_wdata_i;
    end
  end

  // Control register, strobes and stall counter
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_reg <= `NV_MODE_RESET;
      ready_ie_reg <= 1'b0;
      master_reg <= 1'b0;
      master_cnt_reg <= 3'h0;
      prog_reg <= 1'b0;
      read_pend_reg <= 1'b0;
      stall_cnt_reg <= 3'h0;
    end else if (core_rst_i) begin
      if (!prog_reg) begin
        mode_reg <= `NV_MODE_RESET;
      end
      if (timer_done && state_next == ST_IDLE) begin
        prog_reg <= 1'b0;
      end
      ready_ie_reg <= 1'b0;
      master_reg <= 1'b0;
      master_cnt_reg <= 3'h0;
      read_pend_reg <= 1'b0;
      stall_cnt_reg <= 3'h0;
    end else begin
      read_pend_reg <= 1'b0;
      if (stall_cnt_reg != 3'h0) begin
        stall_cnt_reg <= stall_cnt_reg - 3'h1;
      end
      // Master enable times out four cycles after being set
      if (master_reg) begin
        if (master_cnt_reg == `NV_MASTER_WINDOW - 3'h1) begin
          master_reg <= 1'b0;
          master_cnt_reg <= 3'h0;
        end else begin
          master_cnt_reg <= master_cnt_reg + 3'h1;
        end
      end
      if (prog_reg && timer_done && state_next == ST_IDLE) begin
        prog_reg <= 1'b0;
      end
      if (ctrl_wr) begin
        ready_ie_reg <= io_wdata_i[`NV_CTRL_READY_IE];
        if (!prog_reg) begin
          mode_reg <= io_wdata_i[`NV_CTRL_MODE_MSB:`NV_CTRL_MODE_LSB];
        end
        if (io_wdata_i[`NV_CTRL_MASTER_EN]) begin
          master_reg <= 1'b1;
          master_cnt_reg <= 3'h0;
        end
        if (start_prog) begin
          prog_reg <= (mode_reg != `NV_MODE_RSVD);
          master_reg <= 1'b0;
          stall_cnt_reg <= `NV_WRITE_STALL;
        end else if (io_wdata_i[`NV_CTRL_READ_STROBE] && !prog_reg) begin
          read_pend_reg <= 1'b1;
          stall_cnt_reg <= `NV_READ_STALL;
        end
      end
    end
  end

  // ----------------------------------------
  // Read data and core outputs
  // ----------------------------------------
  // Read mux; reserved bits read zero, strobe reads back busy state
  always @* begin
    rdata_next = 8'h00;
    if (hit_ctrl) begin
      rdata_next = {2'h0, mode_reg, ready_ie_reg, master_reg, prog_reg, read_pend_reg};
    end else if (hit_data) begin
      rdata_next = data_reg;
    end else if (hit_lo) begin
      rdata_next = addr_reg[7:0];
    end else if (hit_hi) begin
      rdata_next = {4'h0, addr_reg[11:8]};
    end
  end

  // Registered outputs; address register has no reset value
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      io_rdata_o <= 8'h00;
      io_hit_o <= 1'b0;
      cpu_stall_o <= 1'b0;
      ready_irq_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      io_rdata_o <= io_rd_i ? rdata_next : 8'h00;
      io_hit_o <= (io_rd_i | io_wr_i) & (hit_ctrl | hit_data | hit_lo | hit_hi);
      cpu_stall_o <= (stall_cnt_reg > 3'h1) | (ctrl_wr & (start_prog | (io_wdata_i[0] & ~prog_reg)));
      ready_irq_o <= ready_ie_reg & global_int_en_i & ~prog_reg;
      busy_o <= prog_reg;
    end
  end

endmodule

// ===== verification/nv_access_props.sv
`timescale 1ns/1ps
`include "nv_access_defines.vh"

module nv_access_props (
  // Clock and reset
  input wire ref_clk_i,
  input wire nrst_i,
  input wire core_rst_i,
  // Register bus
  input wire data_space_i,
  input wire [7:0] io_addr_i,
  input wire io_wr_i,
  input wire io_rd_i,
  input wire [7:0] io_wdata_i,
  input wire [7:0] io_rdata_o,
  input wire io_hit_o,
  // Core side
  input wire global_int_en_i,
  input wire cpu_stall_o,
  input wire ready_irq_o,
  input wire busy_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  // Control register write seen in I/O space
  wire ctl_wr = io_wr_i && !core_rst_i && !data_space_i && io_addr_i == {2'h0, `NV_CTRL_ADDR};

  // Stall lengths, start cause and ready request
  AST_READ_STALL: assert property (ctl_wr && io_wdata_i == 8'h01 && !busy_o |=> cpu_stall_o [*4] ##1 !cpu_stall_o)
    else $error("read stall length wrong");
  // Strobe two cycles after a master enable write, so the window is still open
  AST_WRITE_STALL: assert property (ctl_wr && io_wdata_i[2:1] == 2'h3 && !busy_o && !$past(core_rst_i)
    && $past(ctl_wr && io_wdata_i[2], 2) |=> cpu_stall_o [*2] ##1 !cpu_stall_o)
    else $error("write stall length wrong");
  AST_START_CAUSE: assert property ($rose(busy_o) |-> $past(io_wr_i) || $past(io_wr_i, 2))
    else $error("busy without a strobe write");
  AST_IRQ_BUSY: assert property (busy_o && $past(busy_o) |-> !ready_irq_o)
    else $error("ready request while busy");
  AST_IRQ_GLOBAL: assert property (!global_int_en_i && $past(!global_int_en_i) |-> !ready_irq_o)
    else $error("ready request without global enable");
  // Address decode
  AST_UNMAPPED: assert property (io_rd_i && !data_space_i && io_addr_i == 8'h23 |=> !io_hit_o && io_rdata_o == 8'h00)
    else $error("unmapped address answered");
  AST_DATA_SPACE: assert property (io_rd_i && data_space_i && io_addr_i == 8'h42 |=> io_hit_o)
    else $error("data space offset not decoded");
  AST_ADDR_HIGH: assert property (io_rd_i && !data_space_i && io_addr_i == 8'h22 |=> io_rdata_o[7:4] == 4'h0)
    else $error("reserved address bits not zero");
  cover property ($rose(busy_o));
  cover property ($fell(busy_o));
  cover property (ready_irq_o);
endmodule

bind nv_access_ctrl nv_access_props u_props (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .core_rst_i(core_rst_i),
  .data_space_i(data_space_i),
  .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
  .io_hit_o(io_hit_o), .global_int_en_i(global_int_en_i), .cpu_stall_o(cpu_stall_o), .ready_irq_o(ready_irq_o),
  .busy_o(busy_o));

// ===== verification/cpu_bus_model.sv
`timescale 1ns/1ps

module cpu_bus_model (
  // Clock and stall
  input wire ref_clk_i,
  input wire cpu_stall_i,
  // Register bus
  output reg io_wr_o,
  output reg io_rd_o,
  output reg [7:0] io_addr_o,
  output reg [7:0] io_wdata_o,
  input wire [7:0] io_rdata_i,
  // Oscillator and hang flag
  output reg rc_osc_o,
  output reg hang_o
);
  // RC oscillator, 52 ns period, phase unrelated to the clock
  initial begin
    rc_osc_o = 1'b0;
    #7;
    forever #26 rc_osc_o = ~rc_osc_o;
  end

  // Idle bus at time zero
  initial begin
    io_wr_o = 1'b0;
    io_rd_o = 1'b0;
    io_addr_o = 8'h00;
    io_wdata_o = 8'h00;
    hang_o = 1'b0;
  end

  // One access; no request while the core is stalled
  task acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    begin
      n = 0;
      @(posedge ref_clk_i);
      #1;
      while (cpu_stall_i !== 1'b0 && n < 20) begin
        @(posedge ref_clk_i);
        #1;
        n++;
      end
      if (n == 20) hang_o = 1'b1;
      io_wr_o = w;
      io_rd_o = !w;
      io_addr_o = a;
      io_wdata_o = d;
      @(posedge ref_clk_i);
      #1;
      q = io_rdata_i;
      io_wr_o = 1'b0;
      io_rd_o = 1'b0;
      io_addr_o = ~a;
      io_wdata_o = ~d;
    end
  endtask
endmodule

// ===== verification/testbench.sv
`timescale 1ns/1ps

module testbench;
  reg ref_clk_i, nrst_i, core_rst_i, data_space_i, global_int_en_i;
  wire io_wr, io_rd, io_hit, rc_osc, stall, irq, busy, hang;
  wire [7:0] io_addr, io_wdata, io_rdata;
  logic [7:0] v;
  int bad_count, checked, i;

  nv_access_ctrl uut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .core_rst_i(core_rst_i), .rc_osc_i(rc_osc),
    .data_space_i(data_space_i), .io_addr_i(io_addr), .io_wr_i(io_wr), .io_rd_i(io_rd), .io_wdata_i(io_wdata),
    .io_rdata_o(io_rdata), .io_hit_o(io_hit), .global_int_en_i(global_int_en_i), .cpu_stall_o(stall),
    .ready_irq_o(irq), .busy_o(busy));
  cpu_bus_model cpu (.ref_clk_i(ref_clk_i), .cpu_stall_i(stall), .io_wr_o(io_wr), .io_rd_o(io_rd),
    .io_addr_o(io_addr), .io_wdata_o(io_wdata), .io_rdata_i(io_rdata), .rc_osc_o(rc_osc), .hang_o(hang));

  // 40 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  // Compare and count
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    begin
      checked++;
      if (seen !== exp) begin
        bad_count++;
        $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // Bus helpers; reads compare every bit
  task wr(input logic [7:0] a, input logic [7:0] d);
    cpu.acc(1'b1, a, d, v);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    begin
      cpu.acc(1'b0, a, 8'h00, v);
      chk(v, e);
    end
  endtask

  // Bounded wait for the end of programming
  task wait_idle;
    begin
      i = 0;
      // Busy follows the strobe one cycle late, so let it rise first
      repeat (2) @(posedge ref_clk_i);
      while (busy !== 1'b0 && i < 40000) begin
        @(posedge ref_clk_i);
        i++;
      end
      if (i == 40000) begin
        bad_count++;
        report_and_stop;
      end
    end
  endtask

  // Verdict and end of run
  task report_and_stop;
    begin
      $display("Comparisons %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask

  // Stall hang from the bus model
  always @(posedge hang) begin
    bad_count++;
    report_and_stop;
  end

  // Main sequence
  initial begin
    nrst_i = 1'b0;
    core_rst_i = 1'b0;
    data_space_i = 1'b0;
    global_int_en_i = 1'b0;
    bad_count = 0;
    checked = 0;
    repeat (6) @(posedge ref_clk_i);
    #1 nrst_i = 1'b1;
    wr(8'h21, 8'h34);
    wr(8'h22, 8'hff);
    rd(8'h22, 8'h0f);
    rd(8'h21, 8'h34);
    rd(8'h23, 8'h00);
    data_space_i = 1'b1;
    rd(8'h42, 8'h0f);
    data_space_i = 1'b0;
    wr(8'h20, 8'ha5);
    rd(8'h20, 8'ha5);
    global_int_en_i = 1'b1;
    wr(8'h1f, 8'h08);
    repeat (3) @(posedge ref_clk_i);
    #1 chk({7'h0, irq}, 8'h01);
    global_int_en_i = 1'b0;
    repeat (3) @(posedge ref_clk_i);
    chk({7'h0, irq}, 8'h00);
    wr(8'h1f, 8'h02);
    rd(8'h1f, 8'h00);
    wr(8'h1f, 8'h04);
    rd(8'h1f, 8'h04);
    repeat (4) @(posedge ref_clk_i);
    wr(8'h1f, 8'h02);
    rd(8'h1f, 8'h00);
    wr(8'h1f, 8'h34);
    wr(8'h1f, 8'h36);
    rd(8'h1f, 8'h30);
    wr(8'h1f, 8'h04);
    wr(8'h1f, 8'h06);
    rd(8'h1f, 8'h02);
    wr(8'h1f, 8'h12);
    wr(8'h21, 8'h99);
    rd(8'h1f, 8'h02);
    rd(8'h21, 8'h34);
    repeat (30000) @(posedge ref_clk_i);
    chk({7'h0, busy}, 8'h01);
    #1 nrst_i = 1'b0;
    @(posedge ref_clk_i);
    #1 nrst_i = 1'b1;
    rd(8'h1f, 8'h00);
    wr(8'h21, 8'h34);
    wr(8'h22, 8'h00);
    wr(8'h1f, 8'h14);
    wr(8'h1f, 8'h16);
    core_rst_i = 1'b1;
    @(posedge ref_clk_i);
    #1 core_rst_i = 1'b0;
    rd(8'h1f, 8'h12);
    wait_idle;
    wr(8'h1f, 8'h01);
    rd(8'h20, 8'hff);
    rd(8'h1f, 8'h00);
    wr(8'h20, 8'h5a);
    wr(8'h1f, 8'h24);
    wr(8'h1f, 8'h26);
    wait_idle;
    wr(8'h1f, 8'h01);
    rd(8'h20, 8'h5a);
    report_and_stop;
  end
endmodule
